// ==== verilog/mid_engine.sv ====
// inactivity engine: slow-motion / no-motion detection with register space
`timescale 1ns/1ps

// Summary of operation
// RULE_01 - slow mode: N consecutive samples set/clear
// RULE_02 - no-motion: all enabled axes quiet delay
// RULE_03 - decode delay code into seconds
// RULE_04 - delay counted with one second tick
// RULE_05 - mode bit one selects no-motion
// RULE_06 - only enabled axes are compared
// RULE_07 - compare slopes against threshold register
// RULE_08 - threshold step scales with range
// RULE_09 - slope samples spaced by half bandwidth
// RULE_10 - restart only on exact key write
// RULE_11 - restart restores defaults, normal power
// RULE_12 - host waits wake-up time after restart
// RULE_13 - 64 byte-wide registers, addresses 0..3f
// RULE_14 - reserved bits ignored, read undefined
// RULE_15 - host masks reserved bits to zero
// RULE_16 - writes to 00..0e are discarded
// RULE_17 - trigger bits write-only, read zero
// RULE_18 - slope is absolute sample difference
module mid_engine #(
  parameter int TICK_CYC = mid_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // filtered samples, one strobe per 1/(2*bw)
  input wire logic smp_valid,
  input wire mid_pkg::mid_sample_t smp,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // engine outputs
  output logic inact_int,
  output logic normal_mode,
  output logic restart_pulse
);

  // ***********************************************************
  // state and helpers
  // ***********************************************************
  typedef struct packed {
    mid_pkg::mid_cfg_t cfg;
    mid_pkg::mid_sample_t prev;
    logic have_prev;
    logic [2:0] cnt_hi;
    logic [2:0] cnt_lo;
    logic [8:0] sec_cnt;
    logic [24:0] tick_cnt;
    mid_pkg::mid_state_t st;
    logic intr;
    logic norm;
    logic rst_p;
    logic [7:0] rdata;
  } mid_all_t;

  mid_all_t s_q;
  mid_all_t s_d;

  // absolute difference of two 12-bit signed samples
  function automatic logic [12:0] mid_absdiff(input logic [11:0] a,
                                              input logic [11:0] b);
    logic signed [12:0] d;
    d = 13'($signed(a)) - 13'($signed(b));
    return d[12] ? 13'(-d) : d;
  endfunction : mid_absdiff

  // threshold in 12-bit lsb units; sample lsb fixed, step doubles per range
  function automatic logic [12:0] mid_thr(input logic [7:0] th,
                                          input logic [3:0] rng);
    unique case (rng)
      mid_pkg::RANGE_4G: return {4'h0, th, 1'b0};
      mid_pkg::RANGE_8G: return {3'h0, th, 2'b00};
      mid_pkg::RANGE_16G: return {2'h0, th, 3'b000};
      default: return {5'h00, th};
    endcase
  endfunction : mid_thr

  // delay code to seconds; undefined codes 22..31 take the longest mid value
  function automatic logic [8:0] mid_delay(input logic [5:0] c);
    int v;
    v = int'(c);
    if (v <= mid_pkg::NOMO_SHORT_LAST) return 9'(v + 1); // [RULE_03]
    if (v <= mid_pkg::NOMO_MID_LAST) // [RULE_03]
      return 9'(mid_pkg::NOMO_MID_BASE_S +
                (v - 16) * mid_pkg::NOMO_STEP_S);
    if (v < mid_pkg::NOMO_HIGH_FIRST) return 9'd80;
    return 9'(mid_pkg::NOMO_HIGH_BASE_S +
              (v - mid_pkg::NOMO_HIGH_FIRST) * mid_pkg::NOMO_STEP_S);
  endfunction : mid_delay

  // ***********************************************************
  // next state
  // ***********************************************************
  always_comb begin
    logic [12:0] thr;
    logic [2:0] above;
    logic [2:0] en;
    logic any_hi;
    logic [2:0] n_req;
    logic tick;
    s_d = s_q;
    above = 3'h0;
    s_d.rst_p = 1'b0;
    thr = mid_thr(s_q.cfg.thresh, s_q.cfg.range); // [RULE_07] [RULE_08]
    en = {s_q.cfg.axis_sel[mid_pkg::SEL_EN_Z],
          s_q.cfg.axis_sel[mid_pkg::SEL_EN_Y],
          s_q.cfg.axis_sel[mid_pkg::SEL_EN_X]};
    above[0] = mid_absdiff(smp.x, s_q.prev.x) > thr; // [RULE_18]
    above[1] = mid_absdiff(smp.y, s_q.prev.y) > thr; // [RULE_18]
    above[2] = mid_absdiff(smp.z, s_q.prev.z) > thr; // [RULE_18]
    any_hi = |(above & en); // [RULE_06]
    n_req = {1'b0, s_q.cfg.dur[1:0]} + 3'h1;
    tick = (s_q.tick_cnt == 25'(TICK_CYC - 1));
    // free-running second tick; coarse by design, error up to one second
    s_d.tick_cnt = tick ? 25'h0 : s_q.tick_cnt + 25'h1; // [RULE_04]

    // sample pipeline: one strobe per slope interval
    if (smp_valid) begin // [RULE_09]
      s_d.prev = smp;
      s_d.have_prev = 1'b1;
    end

    if (s_q.cfg.axis_sel[mid_pkg::SEL_MODE]) begin // [RULE_05]
      // no-motion: restart timer on any enabled axis moving
      s_d.cnt_hi = 3'h0;
      s_d.cnt_lo = 3'h0;
      if (smp_valid && s_q.have_prev && any_hi) begin
        s_d.sec_cnt = 9'h0;
        s_d.st = mid_pkg::MID_ARMED;
        s_d.intr = 1'b0;
      end else if (tick && s_q.st != mid_pkg::MID_FIRED) begin
        s_d.sec_cnt = s_q.sec_cnt + 9'h1;
        s_d.st = mid_pkg::MID_ARMED;
        if (s_q.sec_cnt + 9'h1 >= mid_delay(s_q.cfg.dur[5:0])) begin
          s_d.st = mid_pkg::MID_FIRED; // [RULE_02]
          s_d.intr = 1'b1;
        end
      end
    end else if (smp_valid && s_q.have_prev) begin
      s_d.sec_cnt = 9'h0;
      // slow-motion: consecutive run counters in both directions
      if (any_hi) begin
        s_d.cnt_lo = 3'h0;
        s_d.cnt_hi = (s_q.cnt_hi < n_req) ? s_q.cnt_hi + 3'h1 : s_q.cnt_hi;
        if (s_q.cnt_hi + 3'h1 >= n_req) s_d.intr = 1'b1; // [RULE_01]
      end else begin
        s_d.cnt_hi = 3'h0;
        s_d.cnt_lo = (s_q.cnt_lo < n_req) ? s_q.cnt_lo + 3'h1 : s_q.cnt_lo;
        if (s_q.cnt_lo + 3'h1 >= n_req) s_d.intr = 1'b0; // [RULE_01]
      end
      s_d.st = s_d.intr ? mid_pkg::MID_FIRED : mid_pkg::MID_IDLE;
    end

    // register writes; low status block is read-only
    if (reg_wr && reg_addr > mid_pkg::ADDR_STATUS_LAST) begin // [RULE_16]
      unique case (reg_addr)
        mid_pkg::ADDR_THRESH: s_d.cfg.thresh = reg_wdata;
        mid_pkg::ADDR_DUR: s_d.cfg.dur = {2'b00, reg_wdata[7:2]};
        // reserved upper bits dropped on write
        mid_pkg::ADDR_AXIS_SEL: s_d.cfg.axis_sel = {4'h0, reg_wdata[3:0]};
        mid_pkg::ADDR_RANGE: s_d.cfg.range = reg_wdata[3:0];
        mid_pkg::ADDR_RESTART: begin
          if (reg_wdata == mid_pkg::RESTART_KEY) begin // [RULE_10]
            s_d = '0; // [RULE_11]
            s_d.cfg.thresh = mid_pkg::RST_THRESH;
            s_d.cfg.dur = mid_pkg::RST_DUR;
            s_d.cfg.axis_sel = mid_pkg::RST_AXIS_SEL;
            s_d.cfg.range = mid_pkg::RST_RANGE;
            s_d.norm = 1'b1;
            s_d.rst_p = 1'b1;
          end
        end
        default: ;
      endcase
    end

    // read mux; write-only locations and unmapped ones read zero
    s_d.rdata = 8'h00; // [RULE_17] [RULE_14]
    if (reg_rd) begin // [RULE_13]
      unique case (reg_addr)
        mid_pkg::ADDR_THRESH: s_d.rdata = s_q.cfg.thresh;
        mid_pkg::ADDR_DUR: s_d.rdata = {s_q.cfg.dur[5:0], 2'b00};
        mid_pkg::ADDR_AXIS_SEL: s_d.rdata = s_q.cfg.axis_sel;
        mid_pkg::ADDR_RANGE: s_d.rdata = {4'h0, s_q.cfg.range};
        mid_pkg::ADDR_INT_STAT: s_d.rdata = {4'h0, s_q.intr, 3'h0};
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ***********************************************************
  // state register
  // ***********************************************************
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
      s_q.cfg.thresh <= mid_pkg::RST_THRESH;
      s_q.cfg.dur <= mid_pkg::RST_DUR;
      s_q.cfg.axis_sel <= mid_pkg::RST_AXIS_SEL;
      s_q.cfg.range <= mid_pkg::RST_RANGE;
      s_q.norm <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign inact_int = s_q.intr;
  assign normal_mode = s_q.norm;
  assign restart_pulse = s_q.rst_p;

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_restart_key: assert property (reg_wr && reg_addr == mid_pkg::ADDR_RESTART
    && reg_wdata == mid_pkg::RESTART_KEY |=> restart_pulse) // [RULE_10]
    else $error("restart key not honoured");
  a_restart_other: assert property (restart_pulse |-> $past(reg_wr) &&
    $past(reg_addr) == mid_pkg::ADDR_RESTART &&
    $past(reg_wdata) == mid_pkg::RESTART_KEY) // [RULE_10]
    else $error("restart without key");
  a_restart_dflt: assert property (restart_pulse |->
    reg_rdata == 8'h00 && !inact_int && normal_mode) // [RULE_11]
    else $error("restart left state");
  a_ro_write: assert property (reg_wr && reg_addr <= mid_pkg::ADDR_STATUS_LAST
    |=> $stable(s_q.cfg)) // [RULE_16]
    else $error("read-only location written");
  a_wo_read: assert property (reg_rd && (reg_addr == mid_pkg::ADDR_RESTART ||
    reg_addr == mid_pkg::ADDR_INT_CTRL) |=> reg_rdata == 8'h00) // [RULE_17]
    else $error("write-only read nonzero");
  a_thr_read: assert property (reg_rd && reg_addr == mid_pkg::ADDR_THRESH
    |=> reg_rdata == $past(s_q.cfg.thresh)) // [RULE_07]
    else $error("threshold readback wrong");
  a_slow_set: assert property (!s_q.cfg.axis_sel[mid_pkg::SEL_MODE] &&
    smp_valid && s_q.have_prev && !reg_wr && !inact_int &&
    s_q.cnt_hi + 3'h1 < {1'b0, s_q.cfg.dur[1:0]} + 3'h1
    |=> !inact_int) // [RULE_01]
    else $error("slow motion fired early");
  a_nomo_move: assert property (s_q.cfg.axis_sel[mid_pkg::SEL_MODE] &&
    smp_valid && s_q.have_prev && !reg_wr && s_d.sec_cnt == 9'h0 &&
    s_q.st != mid_pkg::MID_IDLE |=> !inact_int) // [RULE_02]
    else $error("no-motion held during motion");
  a_tick_wrap: assert property (s_q.tick_cnt == 25'(TICK_CYC - 1)
    |=> s_q.tick_cnt == 25'h0) // [RULE_04]
    else $error("tick period wrong");

  c_slow_fire: cover property (!s_q.cfg.axis_sel[mid_pkg::SEL_MODE]
    ##0 $rose(inact_int));
  c_nomo_fire: cover property (s_q.cfg.axis_sel[mid_pkg::SEL_MODE]
    ##0 $rose(inact_int));
  c_restart: cover property (restart_pulse);
  c_slow_clear: cover property ($fell(inact_int));

endmodule : mid_engine

// ==== verilog/mid_pkg.sv ====
// package: register map, reset values and state types of the inactivity engine
package mid_pkg;
  localparam logic [5:0] ADDR_STATUS_LAST = 6'h0e;
  localparam logic [5:0] ADDR_RESTART = 6'h14;
  localparam logic [5:0] ADDR_AXIS_SEL = 6'h18;
  localparam logic [5:0] ADDR_INT_CTRL = 6'h21;
  localparam logic [5:0] ADDR_DUR = 6'h27;
  localparam logic [5:0] ADDR_THRESH = 6'h29;
  localparam logic [5:0] ADDR_RANGE = 6'h0f;
  localparam logic [5:0] ADDR_INT_STAT = 6'h09;
  localparam logic [7:0] RESTART_KEY = 8'hb6;
  localparam logic [7:0] RST_THRESH = 8'h14;
  localparam logic [7:0] RST_DUR = 8'h00;
  localparam logic [7:0] RST_AXIS_SEL = 8'h00;
  localparam logic [3:0] RST_RANGE = 4'h3;
  // axis select field layout
  localparam int SEL_EN_X = 0;
  localparam int SEL_EN_Y = 1;
  localparam int SEL_EN_Z = 2;
  localparam int SEL_MODE = 3;
  // range codes: 2g, 4g, 8g, 16g; threshold lsb doubles with each step
  localparam logic [3:0] RANGE_2G = 4'h3;
  localparam logic [3:0] RANGE_4G = 4'h5;
  localparam logic [3:0] RANGE_8G = 4'h8;
  localparam logic [3:0] RANGE_16G = 4'h2;
  // no-motion delay timing, in seconds, and clock cycles per one second tick
  localparam int NOMO_SHORT_LAST = 15;
  localparam int NOMO_MID_LAST = 21;
  localparam int NOMO_MID_BASE_S = 40;
  localparam int NOMO_HIGH_FIRST = 32;
  localparam int NOMO_HIGH_BASE_S = 88;
  localparam int NOMO_STEP_S = 8;
  localparam int TICK_PERIOD_S = 1;
  localparam int CLK_HZ = 20000000;
  localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;

  typedef enum logic [1:0] {
    MID_IDLE = 2'b00,
    MID_ARMED = 2'b01,
    MID_FIRED = 2'b10
  } mid_state_t;

  typedef struct packed {
    logic [11:0] x;
    logic [11:0] y;
    logic [11:0] z;
  } mid_sample_t;

  typedef struct packed {
    logic [7:0] thresh;
    logic [7:0] dur;
    logic [7:0] axis_sel;
    logic [3:0] range;
  } mid_cfg_t;
endpackage : mid_pkg

// ==== sim/mid_host.sv ====
// host model: register reads and writes towards the inactivity engine
`timescale 1ns/1ps
module mid_host #(
  parameter int WAKE_UP_WAIT_CYC = 20
) (
  // clock
  input wire logic clk_sys,
  // register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [5:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata
);
  // idle strobes low from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
  end
  // one write; released lines show the inverse so stale data is not reused
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    // config must not be touched until the sensor has woken again
    if (a == mid_pkg::ADDR_RESTART && d == mid_pkg::RESTART_KEY) begin
      repeat (WAKE_UP_WAIT_CYC) @(posedge clk_sys);
    end
  endtask : wr
  // one read; reserved bits are masked to zero before use
  task automatic rd(input logic [5:0] a, input logic [7:0] m,
                    output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata & m;
  endtask : rd
endmodule : mid_host

// ==== sim/mid_engine_test.sv ====
// testbench: register space, restart and both detection modes
`timescale 1ns/1ps
module mid_engine_test;
  localparam int TCK = 4;
  logic clk_sys;
  logic arst_n;
  logic smp_valid;
  mid_pkg::mid_sample_t smp;
  logic reg_wr, reg_rd;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic inact_int, normal_mode, restart_pulse;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_rst = 0;
  // ****************************************************************
  // clock, reset and instances
  // ****************************************************************
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  mid_engine #(.TICK_CYC(TCK)) mid_engine_inst (.clk_sys(clk_sys),
    .arst_n(arst_n), .smp_valid(smp_valid), .smp(smp), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .inact_int(inact_int),
    .normal_mode(normal_mode), .restart_pulse(restart_pulse));
  mid_host mid_host_inst (.clk_sys(clk_sys), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata));
  // count restart pulses; a pulse lasts one cycle so every edge is seen
  always @(posedge clk_sys) begin
    if (restart_pulse === 1'b1) n_rst++;
  end
  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] seen,
                     input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // one sample strobe, then two settling cycles for the registered flag
  task automatic put(input logic [11:0] x, input logic [11:0] y);
    @(posedge clk_sys);
    smp_valid <= 1'b1;
    smp <= '{x: x, y: y, z: 12'h000};
    @(posedge clk_sys);
    smp_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : put
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs;
    mid_host_inst.rd(mid_pkg::ADDR_THRESH, 8'hff, v);
    chk("thresh reset", v, mid_pkg::RST_THRESH);
    chk("normal mode", {7'h00, normal_mode}, 8'h01);
    mid_host_inst.wr(mid_pkg::ADDR_THRESH, 8'h33);
    mid_host_inst.rd(mid_pkg::ADDR_THRESH, 8'hff, v);
    chk("thresh rw", v, 8'h33);
    mid_host_inst.wr(mid_pkg::ADDR_INT_STAT, 8'hff);
    mid_host_inst.rd(mid_pkg::ADDR_INT_STAT, 8'h08, v);
    chk("status ro", v, 8'h00);
    mid_host_inst.wr(mid_pkg::ADDR_INT_CTRL, 8'hff);
    mid_host_inst.rd(mid_pkg::ADDR_INT_CTRL, 8'hff, v);
    chk("clear bit wo", v, 8'h00);
    $display("test regs done");
  endtask : t_regs
  task automatic t_restart;
    mid_host_inst.wr(mid_pkg::ADDR_AXIS_SEL, 8'h0f);
    mid_host_inst.wr(mid_pkg::ADDR_RESTART, 8'hb7);
    mid_host_inst.rd(mid_pkg::ADDR_THRESH, 8'hff, v);
    chk("wrong key", v, 8'h33);
    chk("no pulse", n_rst[7:0], 8'h00);
    mid_host_inst.wr(mid_pkg::ADDR_RESTART, mid_pkg::RESTART_KEY);
    chk("one pulse", n_rst[7:0], 8'h01);
    mid_host_inst.rd(mid_pkg::ADDR_THRESH, 8'hff, v);
    chk("thresh dflt", v, mid_pkg::RST_THRESH);
    mid_host_inst.rd(mid_pkg::ADDR_AXIS_SEL, 8'h0f, v);
    chk("sel dflt", v, mid_pkg::RST_AXIS_SEL);
    mid_host_inst.rd(mid_pkg::ADDR_RESTART, 8'hff, v);
    chk("restart wo", v, 8'h00);
    chk("normal mode", {7'h00, normal_mode}, 8'h01);
    $display("test restart done");
  endtask : t_restart
  // slow mode, x only, n = 2, threshold 20 lsb at 2g
  task automatic t_slow;
    mid_host_inst.wr(mid_pkg::ADDR_AXIS_SEL, 8'h01);
    mid_host_inst.wr(mid_pkg::ADDR_DUR, 8'h04);
    mid_host_inst.wr(mid_pkg::ADDR_RANGE, {4'h0, mid_pkg::RANGE_4G});
    put(12'd0, 12'd0);
    put(12'd30, 12'd0);
    put(12'd60, 12'd0);
    chk("4g scaled", {7'h00, inact_int}, 8'h00);
    mid_host_inst.wr(mid_pkg::ADDR_RANGE, {4'h0, mid_pkg::RANGE_2G});
    put(12'd60, 12'd100);
    put(12'd60, 12'd200);
    chk("y off", {7'h00, inact_int}, 8'h00);
    put(12'd90, 12'd200);
    chk("one above", {7'h00, inact_int}, 8'h00);
    put(12'd120, 12'd200);
    chk("two above", {7'h00, inact_int}, 8'h01);
    mid_host_inst.rd(mid_pkg::ADDR_INT_STAT, 8'h08, v);
    chk("status set", v, 8'h08);
    put(12'd120, 12'd200);
    chk("one below", {7'h00, inact_int}, 8'h01);
    put(12'd120, 12'd200);
    chk("two below", {7'h00, inact_int}, 8'h00);
    $display("test slow done");
  endtask : t_slow
  // no-motion: kick, then time the quiet interval against the code
  task automatic t_nomo(input logic [5:0] code, input int s,
                        input logic [11:0] kx);
    int n;
    mid_host_inst.wr(mid_pkg::ADDR_DUR, {code, 2'b00});
    mid_host_inst.wr(mid_pkg::ADDR_AXIS_SEL, 8'h09);
    // kick must differ from the last sample, else no slope is seen
    @(posedge clk_sys);
    smp_valid <= 1'b1;
    smp <= '{x: kx, y: 12'h000, z: 12'h000};
    @(posedge clk_sys);
    smp_valid <= 1'b0;
    #1;
    // look right after the kicking edge, before a short delay refires
    chk("kick clears", {7'h00, inact_int}, 8'h00);
    n = 0;
    while (inact_int !== 1'b1 && n < (s + 1) * TCK) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (inact_int !== 1'b1) begin
      n_mismatch++;
      $display("BAD nomo timeout expected 1 seen %b", inact_int);
      results();
    end
    // free-running tick: the s-th tick lands up to one tick early
    chk("delay lo", {7'h00, n > (s - 1) * TCK}, 8'h01);
    chk("delay high", {7'h00, n <= s * TCK}, 8'h01);
    $display("test nomo code %0d done", code);
  endtask : t_nomo
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    smp_valid = 1'b0;
    smp = '0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_regs();
    t_restart();
    t_slow();
    t_nomo(6'd0, 1, 12'd600);
    t_nomo(6'd16, 40, 12'd0);
    t_nomo(6'd33, 96, 12'd600);
    results();
  end
endmodule : mid_engine_test
